// ==== slcd_pkg.sv ====
// slcd_pkg: constants, register map and state type of the segment lcd drive control
package slcd_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] IDX_DRIVE_CLOCK = 16'h5070;
  localparam logic [15:0] IDX_PANEL_DISPLAY_CONTROL = 16'h50a0;
  localparam logic [15:0] IDX_FRAME_AND_DUTY_CONTROL = 16'h50a2;
  localparam logic [15:0] IDX_DRIVE_VOLTAGE_REGULATOR_CONTROL = 16'h50a3;
  localparam logic [15:0] IDX_FRAME_IRQ_MASK = 16'h50a5;
  localparam logic [15:0] IDX_FRAME_IRQ_STATUS = 16'h50a6;
  localparam int ADDR_W = 20;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_DRIVE_CLOCK_ENABLE = 0;
  localparam int POS_INVERT_DISPLAY_N = 4;
  localparam int POS_DISPLAY_MODE = 0;
  localparam int POS_FRAME_DIVIDER = 6;
  localparam int POS_DRIVE_DUTY = 0;
  localparam int POS_HEAVY_LOAD = 4;
  localparam int POS_REF_VOLTAGE = 0;
  localparam int POS_FRAME_IRQ = 0;

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_ALL_ON = 2'h2;
  localparam logic [1:0] MODE_ALL_OFF = 2'h3;
  localparam logic [2:0] DUTY_STATIC = 3'h0;
  localparam logic [2:0] DUTY_HALF = 3'h1;
  localparam logic [2:0] DUTY_THIRD = 3'h2;
  localparam logic [2:0] DUTY_QUARTER = 3'h3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0] RST_DISPLAY_MODE = MODE_OFF;
  localparam logic RST_INVERT_DISPLAY_N = 1'b1;
  localparam logic [1:0] RST_FRAME_DIVIDER = 2'h1;
  localparam logic [2:0] RST_DRIVE_DUTY = DUTY_QUARTER;
  localparam logic RST_HEAVY_LOAD = 1'b0;
  localparam logic RST_REF_VOLTAGE = 1'b0;
  localparam logic RST_FRAME_IRQ_ENABLE = 1'b0;
  localparam logic RST_DRIVE_CLOCK_ENABLE = 1'b0;

  // ************************************************************
  // base clock figures
  // ************************************************************
  localparam int LOW_SPEED_OSC_HZ = 32768;
  localparam int LCD_BASE_CLOCK_HZ = 512;
  localparam int SEG_LINES = 32;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic drive_clock_enable;
    logic invert_display_n;
    logic [1:0] display_mode_select;
    logic [1:0] frame_divider_select;
    logic [2:0] drive_duty_select;
    logic heavy_load_protect;
    logic reference_voltage_select;
    logic frame_irq_enable;
    logic frame_irq_flag;
    logic sleep;
    logic [2:0] tick_sync;
    logic [3:0] step_cnt;
    logic [1:0] com_index;
    logic frame_polarity;
    logic frame_pulse;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] com_enable;
    logic [SEG_LINES-1:0] seg_enable;
    logic com_dynamic;
    logic segs_force_on;
    logic segs_force_off;
    logic seg_invert;
    logic supply_on;
    logic nodes_grounded;
    logic drive_clock_gate;
  } slcd_state_s;

endpackage

// ==== slcd_top.sv ====
// slcd_top: segment lcd drive control with apb register slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - invert bit 0 drives panel inverted except in all off, 1 normal; memory untouched.
// - mode 3 all off static, 2 all on dynamic, 1 normal, 0 off.
// - display off stops drive supply and grounds all three voltage nodes.
// - all on/off shape the output directly; commons dynamic on, static off.
// - reset sets display mode to off.
// - sleep forces display off; previous mode returns after sleep.
// - frame divider 0..3 divides base clock by 4, 8, 12, 16; reset 1.
// - in 1/3 duty divisions become 6, 9, 12, 15.
// - 32.768 kHz source gives 512 Hz base, default frame 64 Hz.
// - duty 3..0 gives 1/4, 1/3, 1/2, static commons; 4..7 reserved; reset 3.
// - all 32 segment lines active in every duty.
// - heavy-load protection bit read-write, reset 0.
// - frame interrupt enable gates requests, reset 0.
// - flag sets every frame; request while flag and enable both set.
// - drive clock passes only while its enable bit is 1, reset 0.
module slcd_top
  import slcd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slcd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_active,
  input wire logic lcd_base_clock,
  output logic irq,
  output logic frame_pulse,
  output logic [1:0] com_index,
  output logic frame_polarity,
  output logic [3:0] com_enable,
  output logic [slcd_pkg::SEG_LINES-1:0] seg_enable,
  output logic com_dynamic,
  output logic segs_force_on,
  output logic segs_force_off,
  output logic seg_invert,
  output logic supply_on,
  output logic nodes_grounded,
  output logic heavy_load_protect,
  output logic reference_voltage_select,
  output logic drive_clock_gate
);
  import slcd_pkg::*;

  // ************************************************************
  // reset image
  // ************************************************************
  localparam slcd_state_s RST_STATE = '{
    drive_clock_enable: RST_DRIVE_CLOCK_ENABLE,
    invert_display_n: RST_INVERT_DISPLAY_N,
    display_mode_select: RST_DISPLAY_MODE,
    frame_divider_select: RST_FRAME_DIVIDER,
    drive_duty_select: RST_DRIVE_DUTY,
    heavy_load_protect: RST_HEAVY_LOAD,
    reference_voltage_select: RST_REF_VOLTAGE,
    frame_irq_enable: RST_FRAME_IRQ_ENABLE,
    frame_irq_flag: 1'b0,
    sleep: 1'b0,
    tick_sync: 3'h0,
    step_cnt: 4'h0,
    com_index: 2'h0,
    frame_polarity: 1'b0,
    frame_pulse: 1'b0,
    irq: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0,
    com_enable: 4'h0,
    seg_enable: '0,
    com_dynamic: 1'b0,
    segs_force_on: 1'b0,
    segs_force_off: 1'b0,
    seg_invert: 1'b0,
    supply_on: 1'b0,
    nodes_grounded: 1'b1,
    drive_clock_gate: 1'b0
  };

  slcd_state_s st_reg;
  slcd_state_s st_next;

  logic [1:0] mode_eff;
  logic base_tick;
  logic [4:0] step_len;
  logic [1:0] com_last;
  logic frame_end;
  logic [15:0] idx;
  logic addr_ok;
  logic wr_go;
  logic [31:0] rdata;

  always_comb
  begin
    st_next = st_reg;
    // sleep hides the stored mode, which is kept for the wake-up
    mode_eff = st_reg.sleep ? MODE_OFF : st_reg.display_mode_select;

    // ************************************************************
    // base clock crossing and frame sequencing
    // ************************************************************
    // base clock comes from another domain: two stages, then edge detect
    st_next.tick_sync = {st_reg.tick_sync[1:0], lcd_base_clock};
    base_tick = st_reg.tick_sync[1] & ~st_reg.tick_sync[2];

    // per-common step so that length times commons equals the frame ratio
    // static 1/16 needs sixteen ticks, one more than four bits hold
    unique case (st_reg.drive_duty_select)
      DUTY_THIRD:
      begin
        step_len = {3'h0, st_reg.frame_divider_select} + 5'h2;
        com_last = 2'h2;
      end
      DUTY_HALF:
      begin
        step_len = {2'h0, st_reg.frame_divider_select, 1'b0} + 5'h2;
        com_last = 2'h1;
      end
      DUTY_STATIC:
      begin
        step_len = {1'b0, st_reg.frame_divider_select, 2'h0} + 5'h4;
        com_last = 2'h0;
      end
      DUTY_QUARTER:
      begin
        step_len = {3'h0, st_reg.frame_divider_select} + 5'h1;
        com_last = 2'h3;
      end
      default:
      begin
        // reserved codes behave as quarter duty
        step_len = {3'h0, st_reg.frame_divider_select} + 5'h1;
        com_last = 2'h3;
      end
    endcase

    frame_end = 1'b0;
    st_next.frame_pulse = 1'b0;
    if (!st_reg.drive_clock_enable)
    begin
      st_next.step_cnt = 4'h0;
      st_next.com_index = 2'h0;
    end
    else if (base_tick)
    begin
      if ({1'b0, st_reg.step_cnt} + 5'h1 >= step_len)
      begin
        st_next.step_cnt = 4'h0;
        if (st_reg.com_index >= com_last)
        begin
          st_next.com_index = 2'h0;
          frame_end = 1'b1;
        end
        else
        begin
          st_next.com_index = st_reg.com_index + 2'h1;
        end
      end
      else
      begin
        st_next.step_cnt = st_reg.step_cnt + 4'h1;
      end
    end
    if (frame_end)
    begin
      st_next.frame_pulse = 1'b1;
      st_next.frame_polarity = ~st_reg.frame_polarity;
    end

    // ************************************************************
    // apb slave: one wait-free access, answer registered in setup
    // ************************************************************
    idx = paddr[17:2];
    // misaligned or out-of-range addresses answer with an error
    addr_ok = 1'b0;
    if ((paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:18] == '0))
    begin
      unique case (idx)
        IDX_DRIVE_CLOCK, IDX_PANEL_DISPLAY_CONTROL, IDX_FRAME_AND_DUTY_CONTROL:
          addr_ok = 1'b1;
        IDX_DRIVE_VOLTAGE_REGULATOR_CONTROL, IDX_FRAME_IRQ_MASK, IDX_FRAME_IRQ_STATUS:
          addr_ok = 1'b1;
        default:
          addr_ok = 1'b0;
      endcase
    end
    rdata = 32'h0;
    unique case (idx)
      IDX_DRIVE_CLOCK:
        rdata[POS_DRIVE_CLOCK_ENABLE] = st_reg.drive_clock_enable;
      IDX_PANEL_DISPLAY_CONTROL:
      begin
        rdata[POS_INVERT_DISPLAY_N] = st_reg.invert_display_n;
        rdata[POS_DISPLAY_MODE +: 2] = mode_eff;
      end
      IDX_FRAME_AND_DUTY_CONTROL:
      begin
        rdata[POS_FRAME_DIVIDER +: 2] = st_reg.frame_divider_select;
        rdata[POS_DRIVE_DUTY +: 3] = st_reg.drive_duty_select;
      end
      IDX_DRIVE_VOLTAGE_REGULATOR_CONTROL:
      begin
        rdata[POS_HEAVY_LOAD] = st_reg.heavy_load_protect;
        rdata[POS_REF_VOLTAGE] = st_reg.reference_voltage_select;
      end
      IDX_FRAME_IRQ_MASK:
        rdata[POS_FRAME_IRQ] = st_reg.frame_irq_enable;
      IDX_FRAME_IRQ_STATUS:
        rdata[POS_FRAME_IRQ] = st_reg.frame_irq_flag;
      default:
        rdata = 32'h0;
    endcase

    st_next.pready = 1'b0;
    if (psel && !penable)
    begin
      st_next.pready = 1'b1;
      st_next.pslverr = ~addr_ok;
      st_next.prdata = (addr_ok && !pwrite) ? rdata : 32'h0;
    end

    wr_go = psel && penable && st_reg.pready && pwrite && addr_ok;
    if (wr_go)
    begin
      unique case (idx)
        IDX_DRIVE_CLOCK:
          st_next.drive_clock_enable = pwdata[POS_DRIVE_CLOCK_ENABLE];
        IDX_PANEL_DISPLAY_CONTROL:
        begin
          st_next.invert_display_n = pwdata[POS_INVERT_DISPLAY_N];
          st_next.display_mode_select = pwdata[POS_DISPLAY_MODE +: 2];
        end
        IDX_FRAME_AND_DUTY_CONTROL:
        begin
          st_next.frame_divider_select = pwdata[POS_FRAME_DIVIDER +: 2];
          st_next.drive_duty_select = pwdata[POS_DRIVE_DUTY +: 3];
        end
        IDX_DRIVE_VOLTAGE_REGULATOR_CONTROL:
        begin
          st_next.heavy_load_protect = pwdata[POS_HEAVY_LOAD];
          st_next.reference_voltage_select = pwdata[POS_REF_VOLTAGE];
        end
        IDX_FRAME_IRQ_MASK:
          st_next.frame_irq_enable = pwdata[POS_FRAME_IRQ];
        IDX_FRAME_IRQ_STATUS:
          // write one to clear is resolved below, where a set can still win
          st_next.frame_irq_flag = st_reg.frame_irq_flag;
        default:
          st_next.drive_clock_enable = st_reg.drive_clock_enable;
      endcase
    end

    // ************************************************************
    // frame interrupt: sticky flag, write one to clear, set wins
    // ************************************************************
    if (wr_go && idx == IDX_FRAME_IRQ_STATUS && pwdata[POS_FRAME_IRQ])
    begin
      st_next.frame_irq_flag = 1'b0;
    end
    if (frame_end)
    begin
      st_next.frame_irq_flag = 1'b1;
    end
    st_next.irq = st_next.frame_irq_flag & st_next.frame_irq_enable;

    st_next.sleep = sleep_active;

    // ************************************************************
    // driver controls, from the next state so they track the registers
    // ************************************************************
    mode_eff = st_next.sleep ? MODE_OFF : st_next.display_mode_select;
    st_next.drive_clock_gate = st_next.drive_clock_enable;
    // every mode sets every driver control, so no mode inherits another's shape
    unique case (mode_eff)
      MODE_OFF:
      begin
        // supply stopped, the three drive nodes held at ground
        st_next.supply_on = 1'b0;
        st_next.nodes_grounded = 1'b1;
        st_next.segs_force_on = 1'b0;
        st_next.segs_force_off = 1'b0;
        st_next.com_dynamic = 1'b0;
        st_next.seg_invert = ~st_next.invert_display_n;
      end
      MODE_NORMAL:
      begin
        st_next.supply_on = 1'b1;
        st_next.nodes_grounded = 1'b0;
        st_next.segs_force_on = 1'b0;
        st_next.segs_force_off = 1'b0;
        st_next.com_dynamic = 1'b1;
        st_next.seg_invert = ~st_next.invert_display_n;
      end
      MODE_ALL_ON:
      begin
        // waveform forced on, memory untouched; inversion still applies
        st_next.supply_on = 1'b1;
        st_next.nodes_grounded = 1'b0;
        st_next.segs_force_on = 1'b1;
        st_next.segs_force_off = 1'b0;
        st_next.com_dynamic = 1'b1;
        st_next.seg_invert = ~st_next.invert_display_n;
      end
      MODE_ALL_OFF:
      begin
        // commons static and never inverted, so the panel stays blank
        st_next.supply_on = 1'b1;
        st_next.nodes_grounded = 1'b0;
        st_next.segs_force_on = 1'b0;
        st_next.segs_force_off = 1'b1;
        st_next.com_dynamic = 1'b0;
        st_next.seg_invert = 1'b0;
      end
    endcase
    unique case (st_next.drive_duty_select)
      DUTY_STATIC: st_next.com_enable = 4'h1;
      DUTY_HALF: st_next.com_enable = 4'h3;
      DUTY_THIRD: st_next.com_enable = 4'h7;
      DUTY_QUARTER: st_next.com_enable = 4'hf;
      // reserved codes drive all four commons, as quarter duty does
      default: st_next.com_enable = 4'hf;
    endcase
    if (mode_eff == MODE_OFF)
    begin
      st_next.com_enable = 4'h0;
    end
    st_next.seg_enable = (mode_eff == MODE_OFF) ? '0 : '1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_reg <= RST_STATE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
  assign frame_pulse = st_reg.frame_pulse;
  assign com_index = st_reg.com_index;
  assign frame_polarity = st_reg.frame_polarity;
  assign com_enable = st_reg.com_enable;
  assign seg_enable = st_reg.seg_enable;
  assign com_dynamic = st_reg.com_dynamic;
  assign segs_force_on = st_reg.segs_force_on;
  assign segs_force_off = st_reg.segs_force_off;
  assign seg_invert = st_reg.seg_invert;
  assign supply_on = st_reg.supply_on;
  assign nodes_grounded = st_reg.nodes_grounded;
  assign heavy_load_protect = st_reg.heavy_load_protect;
  assign reference_voltage_select = st_reg.reference_voltage_select;
  assign drive_clock_gate = st_reg.drive_clock_gate;

endmodule

`default_nettype wire

// ==== slcd_top_sva.sv ====
// slcd_top_sva: port checks of the segment lcd drive control
`timescale 1ns/1ps
`default_nettype none
module slcd_top_sva
  import slcd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic sleep_active,
  input wire logic irq,
  input wire logic frame_pulse,
  input wire logic [3:0] com_enable,
  input wire logic [slcd_pkg::SEG_LINES-1:0] seg_enable,
  input wire logic com_dynamic,
  input wire logic segs_force_on,
  input wire logic segs_force_off,
  input wire logic seg_invert,
  input wire logic supply_on,
  input wire logic nodes_grounded,
  input wire logic drive_clock_gate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ******
  // properties
  // ******
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_answer; s_setup ##1 s_access |-> pready; endproperty
  a_answer: assert property (p_answer) else $error("no apb answer");
  property p_irq_rise; $rose(irq) |-> frame_pulse || $past(pwrite && pready) || $past(pwrite && pready, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall; $fell(irq) |-> $past(pwrite && pready) || $past(pwrite && pready, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_pulse; frame_pulse |=> !frame_pulse [*3]; endproperty
  a_pulse: assert property (p_pulse) else $error("frame pulse too long");
  property p_gate; !drive_clock_gate [*3] |-> !frame_pulse; endproperty
  a_gate: assert property (p_gate) else $error("frame while clock gated");
  property p_off; nodes_grounded |-> !supply_on && com_enable == 4'h0 && seg_enable == '0 && !com_dynamic; endproperty
  a_off: assert property (p_off) else $error("display off still drives");
  property p_on; supply_on |-> !nodes_grounded && seg_enable == '1 && (com_enable inside {4'h1, 4'h3, 4'h7, 4'hf}); endproperty
  a_on: assert property (p_on) else $error("active lines wrong");
  property p_all_off; segs_force_off |-> !segs_force_on && !com_dynamic && !seg_invert; endproperty
  a_all_off: assert property (p_all_off) else $error("all off drive wrong");
  property p_all_on; segs_force_on |-> com_dynamic && supply_on; endproperty
  a_all_on: assert property (p_all_on) else $error("all on drive wrong");
  property p_sleep; sleep_active [*4] |-> nodes_grounded; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left display on");
endmodule
bind slcd_top slcd_top_sva u_slcd_top_sva (.clk, .rstn, .psel, .penable, .pwrite, .pready, .sleep_active, .irq,
  .frame_pulse, .com_enable, .seg_enable, .com_dynamic, .segs_force_on, .segs_force_off, .seg_invert, .supply_on,
  .nodes_grounded, .drive_clock_gate);
`default_nettype wire

// ==== slcd_panel_model.sv ====
// slcd_panel_model: passive segment panel that counts driven frames
`timescale 1ns/1ps
`default_nettype none
module slcd_panel_model
  import slcd_pkg::*;
(
  input wire logic clk,
  input wire logic supply_on,
  input wire logic [slcd_pkg::SEG_LINES-1:0] seg_enable,
  input wire logic frame_pulse,
  output int frames,
  output logic dark_fault
);
  // a panel without supply shows nothing, so frames count only while powered
  always_ff @(posedge clk)
  begin
    if (frame_pulse && supply_on)
      frames <= frames + 1;
    dark_fault <= !supply_on && (seg_enable != '0);
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench of the segment lcd drive control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import slcd_pkg::*;
  logic clk, rstn, psel, penable, pwrite, sleep_active, lcd_base_clock, pready, pslverr, irq, err;
  logic frame_pulse, frame_polarity, com_dynamic, segs_force_on, segs_force_off, seg_invert, supply_on;
  logic nodes_grounded, heavy_load_protect, reference_voltage_select, drive_clock_gate, dark_fault;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] com_index;
  logic [3:0] com_enable;
  logic [SEG_LINES-1:0] seg_enable;
  int error_cnt, comparisons, frames;
  localparam logic [15:0] PDC = IDX_PANEL_DISPLAY_CONTROL;
  localparam logic [15:0] FDC = IDX_FRAME_AND_DUTY_CONTROL;
  localparam logic [15:0] VRC = IDX_DRIVE_VOLTAGE_REGULATOR_CONTROL;
  slcd_top u_slcd_top (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleep_active, .lcd_base_clock, .irq, .frame_pulse, .com_index, .frame_polarity, .com_enable, .seg_enable,
    .com_dynamic, .segs_force_on, .segs_force_off, .seg_invert, .supply_on, .nodes_grounded, .heavy_load_protect,
    .reference_voltage_select, .drive_clock_gate);
  slcd_panel_model u_slcd_panel_model (.clk, .supply_on, .seg_enable, .frame_pulse, .frames, .dark_fault);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    check(32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  // one base tick spans ten clocks so a frame pulse lands inside it
  task automatic to_frame(output int n);
    logic seen;
    n = 0;
    seen = 1'b0;
    while (!seen && n < 40)
    begin
      for (int i = 0; i < 10; i++)
      begin
        lcd_base_clock <= (i < 5);
        @(posedge clk);
        if (frame_pulse === 1'b1)
          seen = 1'b1;
      end
      n++;
    end
  endtask
  // ******
  // scenarios
  // ******
  task automatic t_reset();
    check(32'({supply_on, nodes_grounded, com_enable}), 32'h10);
    rdchk(PDC, 32'h10);
    rdchk(FDC, 32'h43);
    rdchk(VRC, 32'h0);
    rdchk(IDX_FRAME_IRQ_MASK, 32'h0);
    rdchk(IDX_DRIVE_CLOCK, 32'h0);
  endtask
  task automatic t_regs();
    apb(1'b1, PDC, 32'hff);
    rdchk(PDC, 32'h13);
    apb(1'b1, FDC, 32'hff);
    rdchk(FDC, 32'hc7);
    apb(1'b1, VRC, 32'hff);
    rdchk(VRC, 32'h11);
    apb(1'b1, IDX_FRAME_IRQ_MASK, 32'hfe);
    rdchk(IDX_FRAME_IRQ_MASK, 32'h0);
    settle();
    check(32'({heavy_load_protect, reference_voltage_select, com_enable}), 32'h3f);
    apb(1'b1, VRC, 32'h0);
    settle();
    check(32'(heavy_load_protect), 32'h0);
    apb(1'b1, 16'h50a1, 32'hff);
    check(32'(err), 32'h1);
    rdchk(16'h50a1, 32'h0);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, PDC, 32'(m));
      settle();
      check(32'({supply_on, nodes_grounded, segs_force_on, segs_force_off, com_dynamic, seg_invert}),
        32'({m != 0, m == 0, m == 2, m == 3, m == 1 || m == 2, m != 3}));
    end
    apb(1'b1, PDC, 32'h11);
    settle();
    check(32'(seg_invert), 32'h0);
  endtask
  task automatic t_duty();
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, FDC, 32'h40 | d);
      settle();
      check(32'(com_enable), (32'h2 << d) - 1);
      check(seg_enable, 32'hffffffff);
    end
  endtask
  task automatic t_frames();
    int n;
    logic p;
    apb(1'b1, IDX_DRIVE_CLOCK, 32'h1);
    for (int d = 0; d < 4; d++)
      for (int v = 0; v < 4; v++)
      begin
        apb(1'b1, FDC, 32'({v[1:0], 3'h0, d[2:0]}));
        to_frame(n);
        p = frame_polarity;
        to_frame(n);
        check(n, d == 2 ? 3 * (v + 2) : 4 * (v + 1));
        check(32'({frame_polarity, com_index}), 32'({!p, 2'h0}));
      end
  endtask
  task automatic t_gate();
    int f, n;
    apb(1'b1, IDX_DRIVE_CLOCK, 32'h0);
    settle();
    f = frames;
    repeat (2) to_frame(n);
    check(frames, f);
    check(32'({drive_clock_gate, dark_fault}), 32'h0);
    apb(1'b1, IDX_DRIVE_CLOCK, 32'h1);
  endtask
  task automatic t_irq();
    int n;
    apb(1'b1, IDX_FRAME_IRQ_STATUS, 32'h1);
    to_frame(n);
    settle();
    check(32'(irq), 32'h0);
    rdchk(IDX_FRAME_IRQ_STATUS, 32'h1);
    apb(1'b1, IDX_FRAME_IRQ_STATUS, 32'h1);
    rdchk(IDX_FRAME_IRQ_STATUS, 32'h0);
    apb(1'b1, IDX_FRAME_IRQ_MASK, 32'h1);
    to_frame(n);
    settle();
    check(32'(irq), 32'h1);
    apb(1'b1, IDX_FRAME_IRQ_STATUS, 32'h1);
    settle();
    check(32'(irq), 32'h0);
  endtask
  task automatic t_sleep();
    sleep_active <= 1'b1;
    settle();
    check(32'({supply_on, dark_fault}), 32'h0);
    rdchk(PDC, 32'h10);
    sleep_active <= 1'b0;
    settle();
    rdchk(PDC, 32'h11);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rstn, psel, penable, pwrite, sleep_active, lcd_base_clock} = 6'h0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_duty();
    t_frames();
    t_gate();
    t_irq();
    t_sleep();
    wrap_up();
  end
  // watchdog well above the longest expected run
  initial
  begin
    #200000;
    error_cnt++;
    $display("mismatch at %0t: watchdog", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
